// File: alarm_map.svh
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH
`define ALARM_STATUS_ADDR   8'h02
`define ALARM_MASK_ADDR     8'h16
`define BIT_BUSY            7
`define BIT_LOCAL_HIGH      6
`define BIT_STATUS_UNUSED   5
`define BIT_REMOTE_HIGH     4
`define BIT_REMOTE_LOW      3
`define BIT_DIODE_FAULT     2
`define BIT_CRIT            1
`define BIT_TACH            0
`define MASK_RESET          8'h00
`define MASK_UNUSED_ONES    8'hA4
`define LATCH_BITS          8'h5F
`define ALERT_BITS          8'h5A
`define STATUS_ZERO         8'h00
`endif

// File: alarm_pkg.sv
package alarm_pkg;
  typedef struct packed {
    logic signed [10:0] remote_temp;
    logic signed [10:0] remote_high;
    logic signed [10:0] remote_low;
    logic signed [7:0]  local_temp;
    logic signed [7:0]  local_high;
    logic signed [7:0]  crit_limit;
    logic        [15:0] tach_count;
    logic        [15:0] tach_limit;
    logic               diode_fault;
  } sense_s;
  typedef struct packed {
    logic       write_en;
    logic       read_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// File: alarm_compare.sv
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"
module alarm_compare (
  input  wire alarm_pkg::sense_s sense,
  output logic [7:0]             cond
);
  import alarm_pkg::*;
  wire signed [10:0] crit_q = {sense.crit_limit, 3'h0};
  wire signed [10:0] rem_int = sense.remote_temp;
  assign cond[`BIT_BUSY]          = 1'b0;
  assign cond[`BIT_LOCAL_HIGH]    = sense.local_temp > sense.local_high;   // [R3]
  assign cond[`BIT_STATUS_UNUSED] = 1'b0;                                  // [R4]
  assign cond[`BIT_REMOTE_HIGH]   = sense.remote_temp > sense.remote_high; // [R5]
  assign cond[`BIT_REMOTE_LOW]    = sense.remote_temp < sense.remote_low;  // [R6]
  assign cond[`BIT_DIODE_FAULT]   = sense.diode_fault;                     // [R7]
  assign cond[`BIT_CRIT]          = rem_int > crit_q;                      // [R8]
  assign cond[`BIT_TACH]          = sense.tach_count > sense.tach_limit;   // [R9]
endmodule
`default_nettype wire

// File: thermal_alarm_status_mask.sv
//Behaviour
//R1 - Alarm bits latch until read, clear if gone
//R2 - Bit 7 shows busy, never alerts
//R3 - Bit 6 local above high setpoint
//R4 - Bit 5 reads zero
//R5 - Bit 4 remote strictly above high setpoint
//R6 - Bit 3 remote strictly below low setpoint
//R7 - Bit 2 diode fault, no alert
//R8 - Bit 1 remote above critical limit
//R9 - Bit 0 tach count above limit
//R10 - Tach alarm never drives alert pin
//R11 - Host polls status for tach alarm
//R12 - Mask bit 7 reads one
//R13 - Mask bit one blocks alert, reset zero
//R14 - Comparator mode: alert follows conditions live
//R15 - Alert from latched unmasked bits, alert pin mode
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"
module thermal_alarm_status_mask (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire alarm_pkg::sense_s sense,
  input  wire logic              busy,
  input  wire logic              comparator_mode,
  input  wire logic              pin_is_alert,
  input  wire alarm_pkg::reg_req_s req,
  output logic [7:0]             rdata,
  output logic                   alert
);
  import alarm_pkg::*;

  // ----------------------------------------
  // Conditions
  // ----------------------------------------
  logic [7:0] cond;
  logic [7:0] status_ff;
  logic [7:0] mask_ff;
  logic [7:0] rdata_ff;
  logic       alert_ff;

  alarm_compare u_cmp (
    .sense (sense),
    .cond  (cond)
  );

  localparam logic [7:0] latch_bits = `LATCH_BITS;
  // Tach and diode fault never reach the pin
  localparam logic [7:0] alertable  = `ALERT_BITS;                          // [R7] [R10]

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  wire        rd_status  = addr_hit(req.read_en, req.addr, `ALARM_STATUS_ADDR);
  wire        rd_mask    = addr_hit(req.read_en, req.addr, `ALARM_MASK_ADDR);
  wire        wr_mask    = addr_hit(req.write_en, req.addr, `ALARM_MASK_ADDR);

  // ----------------------------------------
  // Status latches
  // ----------------------------------------
  wire [7:0]  nxt_status;
  for (genvar b = 0; b < 8; b++) begin : g_stat
    if (latch_bits[b]) begin : g_latch
      // Set wins over read clear
      assign nxt_status[b] = rd_status ? cond[b] : (status_ff[b] | cond[b]);  // [R1]
    end else begin : g_fixed
      assign nxt_status[b] = 1'b0;                                             // [R2] [R4]
    end
  end

  wire [7:0]  status_view = {busy, status_ff[`BIT_LOCAL_HIGH], 1'b0,
                             status_ff[`BIT_REMOTE_HIGH:`BIT_TACH]};          // [R2] [R4]
  wire [7:0]  mask_view  = mask_ff | `MASK_UNUSED_ONES;                        // [R12]
  wire [7:0]  alert_src  = (comparator_mode ? cond : status_ff) & latch_bits;  // [R14]
  wire        nxt_alert  = pin_is_alert && |(alert_src & alertable & ~mask_ff); // [R13] [R15]
  wire [7:0]  nxt_rdata  = rd_status ? status_view : (rd_mask ? mask_view : `STATUS_ZERO);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_ff <= `STATUS_ZERO;
      mask_ff   <= `MASK_RESET;                                                      // [R13]
      rdata_ff  <= `STATUS_ZERO;
      alert_ff  <= 1'b0;
    end else begin
      status_ff <= nxt_status & latch_bits;
      if (wr_mask) begin
        mask_ff <= req.wdata & ~`MASK_UNUSED_ONES;
      end
      rdata_ff  <= nxt_rdata;
      alert_ff  <= nxt_alert;
    end
  end

  assign rdata = rdata_ff;
  assign alert = alert_ff;

  // ----------------------------------------
  // Checks: status latching
  // ----------------------------------------
  chk_latch_hold: assert property (@(posedge clock) disable iff (rst)      // [R1]
    ($past(status_ff[4]) && !$past(rd_status)) |-> status_ff[4]) else $error("alarm bit lost");

  chk_read_clear: assert property (@(posedge clock) disable iff (rst)      // [R1]
    rd_status |=> status_ff == ($past(cond) & latch_bits)) else $error("read clear wrong");

  chk_busy_view: assert property (@(posedge clock) disable iff (rst)       // [R2]
    rd_status |=> rdata[7] == $past(busy)) else $error("busy bit wrong");

  chk_local_set: assert property (@(posedge clock) disable iff (rst)       // [R3]
    cond[6] |=> status_ff[6]) else $error("local alarm not latched");

  chk_local_quiet: assert property (@(posedge clock) disable iff (rst)     // [R3]
    (sense.local_temp <= sense.local_high && !status_ff[6]) |=> !status_ff[6])
    else $error("local alarm spurious");

  chk_unused_zero: assert property (@(posedge clock) disable iff (rst)     // [R4]
    $past(rd_status) |-> !rdata[5]) else $error("status bit 5 set");

  chk_rhigh_set: assert property (@(posedge clock) disable iff (rst)       // [R5]
    (sense.remote_temp > sense.remote_high) |=> status_ff[4]) else $error("remote high missed");

  chk_rhigh_quiet: assert property (@(posedge clock) disable iff (rst)     // [R5]
    (sense.remote_temp <= sense.remote_high && !status_ff[4]) |=> !status_ff[4])
    else $error("remote high spurious");

  chk_rlow_set: assert property (@(posedge clock) disable iff (rst)        // [R6]
    (sense.remote_temp < sense.remote_low) |=> status_ff[3]) else $error("remote low missed");

  chk_rlow_quiet: assert property (@(posedge clock) disable iff (rst)      // [R6]
    (sense.remote_temp >= sense.remote_low && !status_ff[3]) |=> !status_ff[3])
    else $error("remote low spurious");

  chk_fault_set: assert property (@(posedge clock) disable iff (rst)       // [R7]
    sense.diode_fault |=> status_ff[2]) else $error("diode fault missed");

  chk_crit_set: assert property (@(posedge clock) disable iff (rst)        // [R8]
    cond[1] |=> status_ff[1]) else $error("critical not latched");

  chk_crit_quiet: assert property (@(posedge clock) disable iff (rst)      // [R8]
    (sense.remote_temp <= $signed({sense.crit_limit, 3'h0}) && !status_ff[1]) |=> !status_ff[1])
    else $error("critical spurious");

  chk_tach_set: assert property (@(posedge clock) disable iff (rst)        // [R9]
    (sense.tach_count > sense.tach_limit) |=> status_ff[0]) else $error("tach missed");

  chk_tach_clear: assert property (@(posedge clock) disable iff (rst)      // [R9]
    (sense.tach_count <= sense.tach_limit && !status_ff[0]) |=> !status_ff[0])
    else $error("tach spurious");

  // ----------------------------------------
  // Checks: mask register
  // ----------------------------------------
  chk_mask_one: assert property (@(posedge clock) disable iff (rst)        // [R12]
    $past(rd_mask) |-> rdata[7]) else $error("mask bit 7 not one");

  chk_mask_write: assert property (@(posedge clock) disable iff (rst)      // [R13]
    wr_mask |=> mask_ff == ($past(req.wdata) & ~`MASK_UNUSED_ONES)) else $error("mask write lost");

  chk_rdata_idle: assert property (@(posedge clock) disable iff (rst)
    !(rd_status || rd_mask) |=> rdata == `STATUS_ZERO) else $error("read data not idle");

  // ----------------------------------------
  // Checks: alert pin
  // ----------------------------------------
  chk_fault_quiet: assert property (@(posedge clock) disable iff (rst)     // [R7]
    (status_ff == 8'h04 && !comparator_mode) |=> !alert) else $error("fault raised alert");

  chk_busy_quiet: assert property (@(posedge clock) disable iff (rst)      // [R2]
    (busy && status_ff == `STATUS_ZERO && !comparator_mode) |=> !alert)
    else $error("busy raised alert");

  chk_tach_quiet: assert property (@(posedge clock) disable iff (rst)      // [R10]
    (status_ff == 8'h01 && !comparator_mode) |=> !alert) else $error("tach raised alert");

  chk_mask_block: assert property (@(posedge clock) disable iff (rst)      // [R13]
    (mask_view[6:1] == 6'h3F) |=> !alert) else $error("masked alert");

  chk_comp_follow: assert property (@(posedge clock) disable iff (rst)     // [R14]
    (comparator_mode && pin_is_alert && cond[4] && !mask_ff[4]) |=> alert)
    else $error("comparator alert missing");

  chk_comp_release: assert property (@(posedge clock) disable iff (rst)    // [R14]
    (comparator_mode && (cond & alertable & ~mask_ff) == 8'h00) |=> !alert)
    else $error("comparator alert stuck");

  chk_latched_alert: assert property (@(posedge clock) disable iff (rst)   // [R15]
    (!comparator_mode && pin_is_alert && status_ff[6] && !mask_ff[6]) |=> alert)
    else $error("latched alert missing");

  chk_pin_mode: assert property (@(posedge clock) disable iff (rst)        // [R15]
    !pin_is_alert |=> !alert) else $error("alert in tach mode");

  // ----------------------------------------
  // Covers
  // ----------------------------------------
  cov_alert: cover property (@(posedge clock) disable iff (rst) $rose(alert));
  cov_read_clear: cover property (@(posedge clock) disable iff (rst)
    rd_status && status_ff[4] && !cond[4]);
  cov_comp: cover property (@(posedge clock) disable iff (rst) comparator_mode && $fell(alert));
  cov_tach_latch: cover property (@(posedge clock) disable iff (rst)
    status_ff[0] && pin_is_alert);
  cov_mask_block: cover property (@(posedge clock) disable iff (rst)
    mask_view[6:1] == 6'h3F);
endmodule
`default_nettype wire

// File: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic           clock,
  input  wire logic [7:0]     rdata,
  output var alarm_pkg::reg_req_s req
);
  import alarm_pkg::*;
  initial req = '0;
  // Polling access; tach alarm is only seen this way
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clock);
    req <= '{write_en: wr, read_en: !wr, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
    #1 q = rdata;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import alarm_pkg::*;
  logic       clock = 0, rst = 1, busy = 0, comparator_mode = 0, pin_is_alert = 1;
  sense_s     sense, base, s;
  reg_req_s   req;
  logic [7:0] rdata, q;
  logic       alert;
  int         err_count = 0, num_checks = 0;
  logic [7:0] stat_tab [8] = '{8'h00, 8'h10, 8'h08, 8'h40, 8'h12, 8'h01, 8'h04, 8'h10};
  logic [7:0] al_tab = 8'h9E;
  always #50 clock = ~clock;
  thermal_alarm_status_mask dut (.clock(clock), .rst(rst), .sense(sense), .busy(busy),
    .comparator_mode(comparator_mode), .pin_is_alert(pin_is_alert), .req(req),
    .rdata(rdata), .alert(alert));
  host_model host (.clock(clock), .rdata(rdata), .req(req));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  task automatic settle(input sense_s v, input logic exp_alert);
    @(posedge clock);
    sense <= v;
    repeat (4) @(posedge clock);
    #1 check({7'h00, alert}, {7'h00, exp_alert});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    base = '{remote_temp: 11'h000, remote_high: 11'h050, remote_low: 11'h7B0,
             local_temp: 8'h00, local_high: 8'h28, crit_limit: 8'h32,
             tach_count: 16'h000A, tach_limit: 16'h0064, diode_fault: 1'b0};
    sense = base;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(8'h16, 8'hA4);
    rd(8'h02, 8'h00);
    host.access(1'b1, 8'h16, 8'hFF, q);
    rd(8'h16, 8'hFF);
    host.access(1'b1, 8'h16, 8'h00, q);
    for (int i = 0; i < 8; i++) begin
      s = base;
      case (i)
        0: s.remote_temp = 11'h050;
        1: s.remote_temp = 11'h051;
        2: s.remote_temp = 11'h7AF;
        3: s.local_temp = 8'h29;
        4: s.remote_temp = 11'h191;
        5: s.tach_count = 16'h0065;
        6: s.diode_fault = 1'b1;
        default: s.remote_temp = 11'h190;
      endcase
      settle(s, al_tab[i]);
      rd(8'h02, stat_tab[i]);
      settle(base, al_tab[i]);
      rd(8'h02, stat_tab[i]);
      rd(8'h02, 8'h00);
    end
    @(posedge clock) busy <= 1'b1;
    settle(base, 1'b0);
    rd(8'h02, 8'h80);
    @(posedge clock) busy <= 1'b0;
    host.access(1'b1, 8'h16, 8'h10, q);
    settle(s, 1'b0);
    rd(8'h02, 8'h10);
    host.access(1'b1, 8'h16, 8'h00, q);
    @(posedge clock) comparator_mode <= 1'b1;
    settle(s, 1'b1);
    settle(base, 1'b0);
    @(posedge clock) pin_is_alert <= 1'b0;
    settle(s, 1'b0);
    give_verdict();
  end
  initial begin
    #500000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
